// ### smart_card_consts.vh
/*
 * constants of the smart card interface control block: pin vector layout,
 * reset values, supply level codes and timing counts.
 * assumes the includer runs on a single 250 MHz reference clock.
 */
`ifndef SMART_CARD_CONSTS_VH
`define SMART_CARD_CONSTS_VH

// synchronised pin vector layout
`define PIN_W 19
`define PIN_CS 0
`define PIN_VSA 1
`define PIN_VSB 2
`define PIN_ACT_N 3
`define PIN_DVA 4
`define PIN_DVB 5
`define PIN_HRST 6
`define PIN_CARD_PRESENCE_INPUT_N 7
`define PIN_CARD_PRESENCE_INPUT 8
`define PIN_OCP 9
`define PIN_OTP 10
`define PIN_UVP 11
`define PIN_CLKSRC 12
`define PIN_HOST 13
`define PIN_CARD 16
`define PIN_RESET 19'h7E088

// latched control layout
`define CTL_VSA 0
`define CTL_VSB 1
`define CTL_ACT_N 2
`define CTL_DVA 3
`define CTL_DVB 4
`define CTL_HRST 5
`define CTL_RESET 6'h04

// card supply level codes
`define SUPPLY_OFF 2'h0
`define SUPPLY_3V 2'h1
`define SUPPLY_5V 2'h2
`define SUPPLY_1V8 2'h3

// timing
`define REF_CLK_MHZ 250
`define DEBOUNCE_MS 8
// 8 ms at 250 MHz, sized to the 21-bit debounce counter
`define DEBOUNCE_CYCLES 21'h1E8480
`define DEBOUNCE_W 21
`define STEP_NS 1000
`define STEP_CYCLES ((`STEP_NS * `REF_CLK_MHZ) / 1000)
`define RELAY_GUARD 2'h3

`endif

// ### card_clock_divider.v
/*
 * card clock divider: follows the synchronised clock source, divided by
 * 1, 2, 4 or 8. assumes src_i is already synchronised to clk_i.
 */
`timescale 1ns/10ps
module card_clock_divider (
	input wire clk_i,
	input wire srst_i,
	input wire src_i,
	input wire run_i,
	input wire force_low_i,
	input wire [1:0] ratio_sel_i,
	output wire clk_o
);

reg src_prev_reg;
reg [1:0] cnt_reg;
reg [1:0] ratio_reg;
reg out_reg;
reg [1:0] lim;
wire rise = src_i & ~src_prev_reg;

always @* begin
	case (ratio_reg)
	2'h2: lim = 2'h1;
	2'h3: lim = 2'h3;
	default: lim = 2'h0;
	endcase
end

////////////////////////////////////////////////////////////////////////
always @(posedge clk_i) begin
	if (srst_i) begin
		src_prev_reg <= 1'b0;
		cnt_reg <= 2'h0;
		ratio_reg <= 2'h0;
		out_reg <= 1'b0;
	end else begin
		src_prev_reg <= src_i;
		if (force_low_i) begin
			out_reg <= 1'b0;
			cnt_reg <= 2'h0;
			ratio_reg <= ratio_sel_i;
		end else begin
			// new ratio only while low and between periods
			if (!out_reg && cnt_reg == 2'h0)
				ratio_reg <= ratio_sel_i;
			if (ratio_reg == 2'h0) begin
				// divide by one; start only on a source rise so a
				// ratio change or a start never cuts a high phase
				out_reg <= rise ? run_i : (src_i & out_reg);
			end else if (rise) begin
				if (cnt_reg == lim) begin
					cnt_reg <= 2'h0;
					if (out_reg || run_i)
						out_reg <= ~out_reg;
				end else begin
					cnt_reg <= cnt_reg + 2'h1;
				end
			end
		end
	end
end

assign clk_o = out_reg;

endmodule

// ### smart_card_interface_control.v
/*
 * smart card interface control: chip select latching, presence debounce,
 * activation sequencer, fault deactivation, interrupt and io relays.
 * assumes one 250 MHz clock; every pin is asynchronous to it.
 */
`timescale 1ns/10ps
`include "smart_card_consts.vh"
module smart_card_interface_control #(
	parameter [20:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
	input wire REF_CLK_I,
	input wire SRST_I,
	input wire CHIP_SELECT_I,
	input wire SUPPLY_SELECT_A_I,
	input wire SUPPLY_SELECT_B_I,
	input wire ACTIVATION_REQUEST_N_I,
	input wire DIVIDER_SELECT_A_I,
	input wire DIVIDER_SELECT_B_I,
	input wire HOST_RESET_IN_I,
	input wire CARD_PRESENCE_INPUT_N_I,
	input wire CARD_PRESENCE_INPUT_I,
	input wire OVERCURRENT_FAULT_I,
	input wire OVERTEMP_FAULT_I,
	input wire UNDERVOLTAGE_FAULT_I,
	input wire CLOCK_SOURCE_IN_I,
	input wire [2:0] HOST_LINE_I,
	output wire [2:0] HOST_LINE_O,
	output wire [2:0] HOST_LINE_OE_O,
	input wire [2:0] CARD_LINE_I,
	output wire [2:0] CARD_LINE_O,
	output wire [2:0] CARD_LINE_OE_O,
	output wire [1:0] CARD_SUPPLY_OUT_O,
	output wire CARD_CLOCK_OUT_O,
	output wire CARD_RESET_OUT_O,
	output wire CARD_PRESENT_O,
	output wire INTERRUPT_N_O
);

localparam S_OFF = 4'h0;
localparam S_ACT_VCC = 4'h1;
localparam S_ACT_IO = 4'h2;
localparam S_ACT_CLK = 4'h3;
localparam S_ACTIVE = 4'h4;
localparam S_DE_RST = 4'h5;
localparam S_DE_CLK = 4'h6;
localparam S_DE_IO = 4'h7;
localparam integer STEP_LAST_I = `STEP_CYCLES - 1;

wire [7:0] step_last = STEP_LAST_I[7:0];
wire [20:0] debounce_last = DEBOUNCE_CYCLES - 21'h1;
wire [`PIN_W-1:0] pin_raw = {CARD_LINE_I, HOST_LINE_I, CLOCK_SOURCE_IN_I,
	UNDERVOLTAGE_FAULT_I, OVERTEMP_FAULT_I, OVERCURRENT_FAULT_I,
	CARD_PRESENCE_INPUT_I, CARD_PRESENCE_INPUT_N_I, HOST_RESET_IN_I,
	DIVIDER_SELECT_B_I, DIVIDER_SELECT_A_I, ACTIVATION_REQUEST_N_I,
	SUPPLY_SELECT_B_I, SUPPLY_SELECT_A_I, CHIP_SELECT_I};

reg [`PIN_W-1:0] meta_reg;
reg [`PIN_W-1:0] sync_reg;
reg [5:0] ctl_reg;
reg act_prev_reg;
reg [`DEBOUNCE_W-1:0] deb_cnt_reg;
reg present_reg;
reg present_prev_reg;
reg fault_prev_reg;
reg int_n_reg;
reg [3:0] state_reg;
reg [7:0] step_cnt_reg;
reg vcc_on_reg;
reg io_en_reg;
reg clk_run_reg;
reg rst_rel_reg;
reg [1:0] supply_reg;
reg card_rst_reg;
wire card_clk;

////////////////////////////////////////////////////////////////////////
// two-stage synchronisers for every pin
always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		meta_reg <= `PIN_RESET;
		sync_reg <= `PIN_RESET;
	end else begin
		meta_reg <= pin_raw;
		sync_reg <= meta_reg;
	end
end

wire deselect = sync_reg[`PIN_CS];
wire undervolt = sync_reg[`PIN_UVP];
wire hw_fault = sync_reg[`PIN_OCP] | sync_reg[`PIN_OTP] | undervolt;
wire fault = hw_fault | ~present_reg;
wire request_fall = act_prev_reg & ~ctl_reg[`CTL_ACT_N];
wire step_done = (step_cnt_reg == step_last);
// withdrawn request or any fault ends the session
wire deact = fault | ctl_reg[`CTL_ACT_N];

////////////////////////////////////////////////////////////////////////
// control latch: transparent while selected, frozen while deselected
always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		ctl_reg <= `CTL_RESET;
		act_prev_reg <= 1'b1;
	end else begin
		if (!deselect)
			ctl_reg <= sync_reg[`PIN_HRST:`PIN_VSA];
		act_prev_reg <= ctl_reg[`CTL_ACT_N];
	end
end

////////////////////////////////////////////////////////////////////////
// presence: either pin may report a card; the unused one is tied idle
wire raw_present = ~sync_reg[`PIN_CARD_PRESENCE_INPUT_N] | sync_reg[`PIN_CARD_PRESENCE_INPUT];

always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		deb_cnt_reg <= {`DEBOUNCE_W{1'b0}};
		present_reg <= 1'b0;
	end else if (!raw_present) begin
		// removal is taken at once so deactivation is not delayed
		deb_cnt_reg <= {`DEBOUNCE_W{1'b0}};
		present_reg <= 1'b0;
	end else if (!present_reg) begin
		if (deb_cnt_reg == debounce_last)
			present_reg <= 1'b1;
		else
			deb_cnt_reg <= deb_cnt_reg + 21'h1;
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt: low on presence change or new fault, released by next
// activation request; an event in the release cycle keeps it low
always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		present_prev_reg <= 1'b0;
		fault_prev_reg <= 1'b0;
		int_n_reg <= 1'b1;
	end else begin
		present_prev_reg <= present_reg;
		fault_prev_reg <= hw_fault;
		if ((present_reg != present_prev_reg) || (hw_fault && !fault_prev_reg))
			int_n_reg <= 1'b0;
		else if (request_fall)
			int_n_reg <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// activation and deactivation sequencer
always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		state_reg <= S_OFF;
		step_cnt_reg <= 8'h00;
		vcc_on_reg <= 1'b0;
		io_en_reg <= 1'b0;
		clk_run_reg <= 1'b0;
		rst_rel_reg <= 1'b0;
	end else begin
		step_cnt_reg <= step_done ? step_cnt_reg : step_cnt_reg + 8'h01;
		case (state_reg)
		S_OFF: begin
			if (request_fall && present_reg && !hw_fault) begin
				vcc_on_reg <= 1'b1;
				step_cnt_reg <= 8'h00;
				state_reg <= S_ACT_VCC;
			end
		end
		S_ACT_VCC, S_ACT_IO, S_ACT_CLK, S_ACTIVE: begin
			if (deact) begin
				rst_rel_reg <= 1'b0;
				step_cnt_reg <= 8'h00;
				state_reg <= S_DE_RST;
			end else if (step_done && state_reg != S_ACTIVE) begin
				step_cnt_reg <= 8'h00;
				state_reg <= state_reg + 4'h1;
				if (state_reg == S_ACT_VCC)
					io_en_reg <= 1'b1;
				if (state_reg == S_ACT_IO)
					clk_run_reg <= 1'b1;
				if (state_reg == S_ACT_CLK)
					rst_rel_reg <= 1'b1;
			end
		end
		S_DE_RST: begin
			if (step_done) begin
				clk_run_reg <= 1'b0;
				step_cnt_reg <= 8'h00;
				state_reg <= S_DE_CLK;
			end
		end
		S_DE_CLK: begin
			// wait for the divider to park low before freezing io
			if (step_done && !card_clk) begin
				io_en_reg <= 1'b0;
				step_cnt_reg <= 8'h00;
				state_reg <= S_DE_IO;
			end
		end
		S_DE_IO: begin
			if (step_done) begin
				vcc_on_reg <= 1'b0;
				state_reg <= S_OFF;
			end
		end
		default: state_reg <= S_OFF;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// card supply and reset; the latch keeps them during deselect
always @(posedge REF_CLK_I) begin
	if (SRST_I) begin
		supply_reg <= `SUPPLY_OFF;
		card_rst_reg <= 1'b0;
	end else begin
		if (undervolt || !vcc_on_reg)
			supply_reg <= `SUPPLY_OFF;
		else if (!ctl_reg[`CTL_VSB])
			supply_reg <= `SUPPLY_3V;
		else if (ctl_reg[`CTL_VSA])
			supply_reg <= `SUPPLY_1V8;
		else
			supply_reg <= `SUPPLY_5V;
		card_rst_reg <= ~undervolt & rst_rel_reg & ctl_reg[`CTL_HRST];
	end
end

card_clock_divider u_divider (
	.clk_i(REF_CLK_I),
	.srst_i(SRST_I),
	.src_i(sync_reg[`PIN_CLKSRC]),
	.run_i(clk_run_reg),
	.force_low_i(undervolt),
	.ratio_sel_i({ctl_reg[`CTL_DVB], ctl_reg[`CTL_DVA]}),
	.clk_o(card_clk)
);

////////////////////////////////////////////////////////////////////////
// io relays: the first side to pull low owns the line until it lets
// go; a guard period then hides our own echo through the synchronisers
localparam R_IDLE = 2'h0;
localparam R_H2C = 2'h1;
localparam R_C2H = 2'h2;
localparam R_GUARD = 2'h3;

wire link_ok = io_en_reg & ~undervolt & ~deselect;
wire card_park = vcc_on_reg & ~io_en_reg & ~undervolt;

genvar i;
generate
	for (i = 0; i < 3; i = i + 1) begin : relay
		reg [1:0] st_reg;
		reg [1:0] st_next;
		reg [1:0] guard_reg;
		reg host_oe_reg;
		reg card_oe_reg;
		wire host_in = sync_reg[`PIN_HOST + i];
		wire card_in = sync_reg[`PIN_CARD + i];

		always @* begin
			st_next = st_reg;
			case (st_reg)
			R_IDLE: begin
				// a disabled link waits in guard: the parked card
				// line would otherwise echo low when io is enabled
				if (!link_ok)
					st_next = R_GUARD;
				else if (!host_in)
					st_next = R_H2C;
				else if (!card_in)
					st_next = R_C2H;
			end
			R_H2C: if (!link_ok || host_in) st_next = R_GUARD;
			R_C2H: if (!link_ok || card_in) st_next = R_GUARD;
			R_GUARD: if (link_ok && guard_reg == `RELAY_GUARD)
				st_next = R_IDLE;
			default: st_next = R_IDLE;
			endcase
		end

		always @(posedge REF_CLK_I) begin
			if (SRST_I) begin
				st_reg <= R_IDLE;
				guard_reg <= 2'h0;
				host_oe_reg <= 1'b0;
				card_oe_reg <= 1'b0;
			end else begin
				st_reg <= st_next;
				guard_reg <= (st_reg == R_GUARD && link_ok) ?
					guard_reg + 2'h1 : 2'h0;
				host_oe_reg <= (st_next == R_C2H) & link_ok;
				card_oe_reg <= ((st_next == R_H2C) & link_ok) | card_park;
			end
		end

		assign HOST_LINE_OE_O[i] = host_oe_reg;
		assign CARD_LINE_OE_O[i] = card_oe_reg;
	end
endgenerate

// lines are only ever pulled low; the pull-ups supply the high level
assign HOST_LINE_O = 3'h0;
assign CARD_LINE_O = 3'h0;
assign CARD_SUPPLY_OUT_O = supply_reg;
assign CARD_CLOCK_OUT_O = card_clk;
assign CARD_RESET_OUT_O = card_rst_reg;
assign CARD_PRESENT_O = present_reg;
assign INTERRUPT_N_O = int_n_reg;

endmodule

// ### smart_card_interface_control_chk.sv
/* checker: port-level properties of the smart card control block.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module smart_card_interface_control_chk #(
	parameter [20:0] DEBOUNCE_CYCLES = 21'h10
) (
	input wire REF_CLK_I,
	input wire SRST_I,
	input wire CHIP_SELECT_I,
	input wire CARD_PRESENCE_INPUT_N_I,
	input wire CARD_PRESENCE_INPUT_I,
	input wire OVERCURRENT_FAULT_I,
	input wire OVERTEMP_FAULT_I,
	input wire UNDERVOLTAGE_FAULT_I,
	input wire [2:0] HOST_LINE_I,
	input wire [2:0] HOST_LINE_OE_O,
	input wire [2:0] CARD_LINE_I,
	input wire [2:0] CARD_LINE_OE_O,
	input wire [1:0] CARD_SUPPLY_OUT_O,
	input wire CARD_CLOCK_OUT_O,
	input wire CARD_RESET_OUT_O,
	input wire CARD_PRESENT_O,
	input wire INTERRUPT_N_O
);
default clocking cb @(posedge REF_CLK_I); endclocking
default disable iff (SRST_I);
////////////////////////////////////////////////////////////////////////
// counts how long the raw presence pins have reported a card
reg [20:0] raw_cnt_reg;
wire raw_present = !CARD_PRESENCE_INPUT_N_I || CARD_PRESENCE_INPUT_I;
always @(posedge REF_CLK_I) begin
	if (SRST_I || !raw_present)
		raw_cnt_reg <= 21'h0;
	else
		raw_cnt_reg <= raw_cnt_reg + 21'h1;
end
// faults are left out so a deselected card may still be shut down
sequence s_quiet_desel;
	(CHIP_SELECT_I && CARD_PRESENT_O && !OVERCURRENT_FAULT_I &&
		!OVERTEMP_FAULT_I && !UNDERVOLTAGE_FAULT_I)[*6];
endsequence
sequence s_normal_off;
	CARD_SUPPLY_OUT_O == 2'h0 && $past(CARD_SUPPLY_OUT_O) != 2'h0 &&
		!$past(UNDERVOLTAGE_FAULT_I, 2);
endsequence
////////////////////////////////////////////////////////////////////////
AST_UV_OFF: assert property (UNDERVOLTAGE_FAULT_I[*5] |->
	CARD_SUPPLY_OUT_O == 2'h0 && !CARD_CLOCK_OUT_O)
	else $error("card pins alive under regulator undervoltage");
AST_CS_HOST: assert property (CHIP_SELECT_I[*5] |->
	HOST_LINE_OE_O == 3'h0)
	else $error("host line driven while deselected");
AST_SUPPLY_HOLD: assert property (s_quiet_desel |->
	$stable(CARD_SUPPLY_OUT_O))
	else $error("card supply changed while deselected");
AST_OFF_STATE: assert property (CARD_SUPPLY_OUT_O == 2'h0 |->
	!CARD_RESET_OUT_O && !CARD_CLOCK_OUT_O && CARD_LINE_OE_O == 3'h0)
	else $error("card pin active with supply off");
AST_OFF_ORDER: assert property (s_normal_off |->
	!$past(CARD_RESET_OUT_O, 200) && !$past(CARD_CLOCK_OUT_O))
	else $error("supply removed before reset and clock went low");
AST_INT_CARD_PRESENCE_INPUT: assert property ($changed(CARD_PRESENT_O) |=>
	!INTERRUPT_N_O)
	else $error("no interrupt on presence change");
AST_DEBOUNCE: assert property ($rose(CARD_PRESENT_O) |->
	raw_cnt_reg >= DEBOUNCE_CYCLES)
	else $error("presence accepted before debounce ran out");
AST_RELAY_HC: assert property ($rose(CARD_LINE_OE_O[0]) &&
	CARD_RESET_OUT_O |-> !$past(HOST_LINE_I[0], 2))
	else $error("card line pulled without host line low");
AST_RELAY_CH: assert property ($rose(HOST_LINE_OE_O[1]) |->
	!$past(CARD_LINE_I[1], 2) && !$past(CARD_LINE_OE_O[1]))
	else $error("host line pulled without card line low");
endmodule
bind smart_card_interface_control smart_card_interface_control_chk #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I),
	.CHIP_SELECT_I(CHIP_SELECT_I),
	.CARD_PRESENCE_INPUT_N_I(CARD_PRESENCE_INPUT_N_I),
	.CARD_PRESENCE_INPUT_I(CARD_PRESENCE_INPUT_I),
	.OVERCURRENT_FAULT_I(OVERCURRENT_FAULT_I),
	.OVERTEMP_FAULT_I(OVERTEMP_FAULT_I),
	.UNDERVOLTAGE_FAULT_I(UNDERVOLTAGE_FAULT_I),
	.HOST_LINE_I(HOST_LINE_I), .HOST_LINE_OE_O(HOST_LINE_OE_O),
	.CARD_LINE_I(CARD_LINE_I), .CARD_LINE_OE_O(CARD_LINE_OE_O),
	.CARD_SUPPLY_OUT_O(CARD_SUPPLY_OUT_O),
	.CARD_CLOCK_OUT_O(CARD_CLOCK_OUT_O),
	.CARD_RESET_OUT_O(CARD_RESET_OUT_O),
	.CARD_PRESENT_O(CARD_PRESENT_O), .INTERRUPT_N_O(INTERRUPT_N_O));

// ### contact_card_model.sv
/* contact card model: three open-drain card lines with pull-up to the
   card supply. assumes the block only ever pulls a line low. */
`timescale 1ns/10ps
module contact_card_model (
	input wire [1:0] supply_i,
	input wire [2:0] dut_oe_i,
	input wire [2:0] card_drive_i,
	output wire [2:0] line_o
);
// pull-up hangs on the card supply, so an unpowered card reads low
assign line_o = (supply_i == 2'h0) ? 3'h0 : ~(dut_oe_i | card_drive_i);
endmodule

// ### test_smart_card_interface_control.sv
/* testbench: plays host and card, checks supply, clock, relays and
   interrupt. assumes debounce shortened to 16 cycles. */
`timescale 1ns/10ps
module test_smart_card_interface_control;
reg clk = 1'b0, srst = 1'b1, cs = 1'b0, vsa = 1'b0, vsb = 1'b0;
reg act_n = 1'b1, dva = 1'b0, dvb = 1'b0, hrst = 1'b0, card_presence_input_n = 1'b1;
reg card_presence_input = 1'b0, overcurrent_fault = 1'b0, otp = 1'b0, uv = 1'b0, src = 1'b0;
reg [2:0] hdrv = 3'h0, cdrv = 3'h0;
wire [2:0] h_oe, c_oe, c_line, h_line, h_o, c_o;
wire [1:0] sup;
wire card_clock_out, card_reset_out, card_presence_input_o, int_n;
integer bad_count = 0, tests_run = 0, i, n;
assign h_line = ~(h_oe | hdrv);
initial forever #2 clk = ~clk;
// 25 MHz source, inside the allowed input range
initial forever begin repeat (5) @(posedge clk); #1 src = ~src; end
smart_card_interface_control #(.DEBOUNCE_CYCLES(21'h10)) dut (
	.REF_CLK_I(clk), .SRST_I(srst), .CHIP_SELECT_I(cs),
	.SUPPLY_SELECT_A_I(vsa), .SUPPLY_SELECT_B_I(vsb),
	.ACTIVATION_REQUEST_N_I(act_n), .DIVIDER_SELECT_A_I(dva),
	.DIVIDER_SELECT_B_I(dvb), .HOST_RESET_IN_I(hrst),
	.CARD_PRESENCE_INPUT_N_I(card_presence_input_n), .CARD_PRESENCE_INPUT_I(card_presence_input),
	.OVERCURRENT_FAULT_I(overcurrent_fault), .OVERTEMP_FAULT_I(otp),
	.UNDERVOLTAGE_FAULT_I(uv), .CLOCK_SOURCE_IN_I(src),
	.HOST_LINE_I(h_line), .HOST_LINE_O(h_o), .HOST_LINE_OE_O(h_oe),
	.CARD_LINE_I(c_line), .CARD_LINE_O(c_o), .CARD_LINE_OE_O(c_oe),
	.CARD_SUPPLY_OUT_O(sup), .CARD_CLOCK_OUT_O(card_clock_out),
	.CARD_RESET_OUT_O(card_reset_out), .CARD_PRESENT_O(card_presence_input_o),
	.INTERRUPT_N_O(int_n));
contact_card_model card (.supply_i(sup), .dut_oe_i(c_oe),
	.card_drive_i(cdrv), .line_o(c_line));
////////////////////////////////////////////////////////////////////////
task wt(input integer k);
	begin
		repeat (k) @(posedge clk);
		#1;
	end
endtask
task chk(input string nm, input [3:0] e, input [3:0] g);
	begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	end
endtask
// counts card clock rising edges, sampled once per reference cycle
task cnt_clk(input integer k);
	reg p;
	begin
		n = 0;
		p = card_clock_out;
		repeat (k) begin
			wt(1);
			if (card_clock_out && !p)
				n = n + 1;
			p = card_clock_out;
		end
	end
endtask
task end_of_test;
	begin
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
endtask
initial begin
	#300000;
	bad_count = bad_count + 1;
	end_of_test;
end
////////////////////////////////////////////////////////////////////////
initial begin
	wt(20);
	srst = 1'b0;
	wt(1);
	chk("supply", 4'h0, sup);
	chk("intr", 4'h1, int_n);
	card_presence_input_n = 1'b0;
	wt(12);
	chk("present", 4'h0, card_presence_input_o);
	wt(12);
	chk("present", 4'h1, card_presence_input_o);
	chk("intr", 4'h0, int_n);
	chk("host out", 4'h0, h_o);
	chk("card out", 4'h0, c_o);
	$display("test presence done");
	for (i = 0; i < 4; i = i + 1) begin
		{vsa, vsb} = i[1:0];
		{dvb, dva} = i[1:0];
		hrst = 1'b1;
		act_n = 1'b0;
		wt(10);
		chk("supply", (i == 1) ? 4'h2 : (i == 3) ? 4'h3 : 4'h1, sup);
		chk("intr", 4'h1, int_n);
		wt(246);
		chk("host oe", 4'h0, h_oe);
		wt(554);
		chk("card reset", 4'h1, card_reset_out);
		cnt_clk(640);
		chk("clock edges", 4'h1, n >= (64 >> i) - 1 && n <= (64 >> i) + 1);
		if (i == 0) begin
			cs = 1'b1;
			wt(6);
			{vsa, vsb, act_n, hrst} = 4'hE;
			hdrv = 3'h1;
			cdrv = 3'h2;
			wt(300);
			chk("supply", 4'h1, sup);
			chk("card reset", 4'h1, card_reset_out);
			chk("card oe", 4'h0, c_oe);
			chk("host oe", 4'h0, h_oe);
			cnt_clk(64);
			chk("clock runs", 4'h1, n > 0);
			hdrv = 3'h0;
			cdrv = 3'h0;
			cs = 1'b0;
			wt(10);
			chk("card reset", 4'h0, card_reset_out);
		end
		if (i == 1) begin
			hdrv = 3'h1;
			wt(6);
			chk("card line", 4'h6, c_line);
			hdrv = 3'h0;
			wt(12);
			cdrv = 3'h2;
			wt(6);
			chk("host line", 4'h5, h_line);
			cdrv = 3'h0;
			wt(12);
			chk("host line", 4'h7, h_line);
		end
		act_n = 1'b1;
		wt(1100);
		chk("supply", 4'h0, sup);
		chk("card oe", 4'h0, c_oe);
	end
	$display("test sessions done");
	for (i = 0; i < 3; i = i + 1) begin
		act_n = 1'b0;
		wt(300);
		{uv, overcurrent_fault, otp} = 3'h4 >> i;
		wt(8);
		chk("intr", 4'h0, int_n);
		if (i == 0)
			chk("supply", 4'h0, sup);
		wt(1100);
		chk("supply", 4'h0, sup);
		{uv, overcurrent_fault, otp} = 3'h0;
		act_n = 1'b1;
		wt(10);
	end
	card_presence_input_n = 1'b1;
	wt(6);
	chk("present", 4'h0, card_presence_input_o);
	card_presence_input = 1'b1;
	wt(30);
	chk("present", 4'h1, card_presence_input_o);
	$display("test faults done");
	end_of_test;
end
endmodule
